// File: amt_pkg.sv
package amt_pkg;
  // ------------------------------------------------------------
  // register offsets (word index on the plain port)
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_COMMAND = 4'h0;
  localparam logic [3:0] OFF_INT_ENABLE = 4'h1;
  localparam logic [3:0] OFF_MODE = 4'h3;
  localparam logic [3:0] OFF_DATA_LOW = 4'h6;
  localparam logic [3:0] OFF_DATA_HIGH = 4'h7;
  localparam logic [3:0] OFF_STATUS3 = 4'h3;
  localparam logic [3:0] OFF_READ_LOW = 4'h6;
  localparam logic [3:0] OFF_READ_HIGH = 4'h7;
  localparam logic [3:0] OFF_INT_STATUS = 4'h8;
  localparam logic [3:0] OFF_PAGE = 4'h9;
  // ------------------------------------------------------------
  // commands and fields
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_LOAD_VALUE = 8'h16;
  localparam logic [7:0] CMD_READ_COUNT = 8'h38;
  localparam logic [7:0] CMD_START = 8'h73;
  localparam logic [7:0] CMD_STOP = 8'h74;
  localparam int MODE_REPEAT_BIT = 14;
  localparam int INT_ENABLE_BIT = 9;
  localparam int STATUS_RUN_BIT = 10;
  localparam int COUNT_W = 31;
  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [30:0] VALUE_RESET = 31'h0000_0001;
  localparam int CLOCK_HZ = 16000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000000 * TICK_US;
  localparam logic [3:0] PRESCALE_LAST = 4'(TICK_CYCLES - 1);
endpackage

// File: amt_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - timer value 1 to 2147483647 microseconds
// - 31-bit counter from zero, one per microsecond
// - once mode stops when count reaches value
// - repeat mode restarts from zero until stopped
// - expiry pulse offered as sync activation factor
// - expiry can raise host interrupt
// - new value accepted and used while running
// - mode bit 14 selects once or repeat
// - start by command 73h or sync action
// - stop by command 74h or sync action
// - sync actions copy count, start, stop
// - counter cleared to zero whenever stopped
// - command 38h latches the counter value for reading
// - status bit 10 page one shows running
// - interrupt only when enable bit 9 set
module amt_timer (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic sync_copy,
  input wire logic sync_start,
  input wire logic sync_stop,
  output logic timer_up,
  output logic [30:0] multipurpose_compare_reg,
  output logic copy_done,
  output logic timer_running,
  output logic irq
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] data_low_write_reg;
    logic [15:0] data_high_write_reg;
    logic [15:0] mode_write_reg;
    logic [15:0] interrupt_enable_reg;
    // programmed period in microseconds
    logic [30:0] value;
    logic [30:0] current_timer_count;
    // cycles spent so far in the current microsecond
    logic [3:0] prescale;
    logic running;
    // snapshot taken by the read-count command; top bit stays zero
    logic [31:0] read_latch;
    logic page_one;
    logic int_status;
    // registered outputs
    logic [15:0] rdata;
    logic timer_up;
    logic [30:0] mpr;
    logic copy_done;
    logic irq;
  } amt_state_t;

  amt_state_t cur;
  amt_state_t next_s;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // the high data word only carries bits 30:16; its top bit is dropped
  function automatic logic [30:0] join_value(input logic [15:0] high, input logic [15:0] low);
    return {high[14:0], low};
  endfunction

  // commands carry their code in the low byte of the command write
  function automatic logic is_code(input logic [15:0] word, input logic [7:0] code);
    return word[7:0] == code;
  endfunction

  // one microsecond has passed when the prescaler sits on its last count
  function automatic logic tick_due(input logic run, input logic [3:0] pre);
    return run && pre == amt_pkg::PRESCALE_LAST;
  endfunction

  // the prescaler rests at zero while stopped, so a start always waits a full microsecond
  function automatic logic [3:0] prescale_step(input logic run, input logic [3:0] pre);
    logic [3:0] step;
    step = 4'h0;
    if (run && pre != amt_pkg::PRESCALE_LAST) begin
      step = pre + 4'h1;
    end
    return step;
  endfunction

  // >= rather than == so a value lowered below the count still ends this period
  function automatic logic reaches_value(input logic [30:0] count, input logic [30:0] limit);
    return count + 31'h0000_0001 >= limit;
  endfunction

  // the running flag is shown on page one only; page zero bits are not kept here
  function automatic logic [15:0] status_three_word(input logic page, input logic run);
    logic [15:0] word;
    word = 16'h0000;
    if (page) begin
      word[amt_pkg::STATUS_RUN_BIT] = run;
    end
    return word;
  endfunction

  // the status flag sits at the same position as its enable bit
  function automatic logic [15:0] int_status_word(input logic flag);
    logic [15:0] word;
    word = 16'h0000;
    word[amt_pkg::INT_ENABLE_BIT] = flag;
    return word;
  endfunction

  // the latched count is read as two halves
  function automatic logic [15:0] latch_half(input logic [31:0] latch, input logic upper);
    return upper ? latch[31:16] : latch[15:0];
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // one pass works out the whole next state from the current one
  always_comb begin
    logic start;
    logic stop;
    logic tick;
    logic expire;
    logic cmd_write;
    logic load_cmd;
    logic latch_cmd;
    logic start_cmd;
    logic stop_cmd;
    logic [30:0] loaded;
    start = 1'b0;
    stop = 1'b0;
    tick = 1'b0;
    expire = 1'b0;
    // every command is a write of its code to the command word
    cmd_write = wr && hit(addr, amt_pkg::OFF_COMMAND);
    load_cmd = cmd_write && is_code(wdata, amt_pkg::CMD_LOAD_VALUE);
    latch_cmd = cmd_write && is_code(wdata, amt_pkg::CMD_READ_COUNT);
    start_cmd = cmd_write && is_code(wdata, amt_pkg::CMD_START);
    stop_cmd = cmd_write && is_code(wdata, amt_pkg::CMD_STOP);
    // the data words written in earlier cycles form the value
    loaded = join_value(cur.data_high_write_reg, cur.data_low_write_reg);
    next_s = cur;
    next_s.timer_up = 1'b0;
    next_s.copy_done = 1'b0;
    next_s.rdata = 16'h0000;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    if (wr) begin
      if (hit(addr, amt_pkg::OFF_DATA_LOW)) begin
        next_s.data_low_write_reg = wdata;
      end
      if (hit(addr, amt_pkg::OFF_DATA_HIGH)) begin
        next_s.data_high_write_reg = wdata;
      end
      if (hit(addr, amt_pkg::OFF_MODE)) begin
        next_s.mode_write_reg = wdata;
      end
      if (hit(addr, amt_pkg::OFF_INT_ENABLE)) begin
        next_s.interrupt_enable_reg = wdata;
      end
      if (hit(addr, amt_pkg::OFF_PAGE)) begin
        next_s.page_one = wdata[0];
      end
    end

    // ------------------------------------------------------------
    // commands
    // ------------------------------------------------------------
    // zero is outside the legal range; keep the previous value
    if (load_cmd && loaded != 31'h0000_0000) begin
      next_s.value = loaded;
    end
    // the count is frozen here so its two halves read as one value
    if (latch_cmd) begin
      next_s.read_latch = {1'b0, cur.current_timer_count};
    end
    if (start_cmd) begin
      start = 1'b1;
    end
    if (stop_cmd) begin
      stop = 1'b1;
    end

    // ------------------------------------------------------------
    // synchronous actions
    // ------------------------------------------------------------
    if (sync_start) begin
      start = 1'b1;
    end
    if (sync_stop) begin
      stop = 1'b1;
    end
    if (sync_copy) begin
      next_s.mpr = cur.current_timer_count;
      next_s.copy_done = 1'b1;
    end

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    tick = tick_due(cur.running, cur.prescale);
    next_s.prescale = prescale_step(cur.running, cur.prescale);
    if (tick) begin
      next_s.current_timer_count = cur.current_timer_count + 31'h0000_0001;
      // compared against the value as it stands after this cycle's load
      if (reaches_value(cur.current_timer_count, next_s.value)) begin
        expire = 1'b1;
        next_s.current_timer_count = 31'h0000_0000;
        next_s.running = cur.mode_write_reg[amt_pkg::MODE_REPEAT_BIT];
      end
    end
    next_s.timer_up = expire;

    // ------------------------------------------------------------
    // start and stop
    // ------------------------------------------------------------
    // stop wins over start when both arrive together
    if (start) begin
      next_s.running = 1'b1;
      next_s.prescale = 4'h0;
      next_s.current_timer_count = 31'h0000_0000;
    end
    if (stop) begin
      next_s.running = 1'b0;
      next_s.current_timer_count = 31'h0000_0000;
      next_s.prescale = 4'h0;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // unmapped indexes read as zero; only the interrupt status has a read side effect
    if (rd) begin
      if (hit(addr, amt_pkg::OFF_STATUS3)) begin
        next_s.rdata = status_three_word(cur.page_one, cur.running);
      end
      if (hit(addr, amt_pkg::OFF_READ_LOW)) begin
        next_s.rdata = latch_half(cur.read_latch, 1'b0);
      end
      if (hit(addr, amt_pkg::OFF_READ_HIGH)) begin
        next_s.rdata = latch_half(cur.read_latch, 1'b1);
      end
      if (hit(addr, amt_pkg::OFF_INT_STATUS)) begin
        next_s.rdata = int_status_word(cur.int_status);
        next_s.int_status = 1'b0;
      end
      if (hit(addr, amt_pkg::OFF_PAGE)) begin
        next_s.rdata = {15'h0000, cur.page_one};
      end
    end

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // set beats read-clear so an expiry in the reading cycle is not lost
    if (expire) begin
      next_s.int_status = 1'b1;
    end
    next_s.irq = next_s.int_status && next_s.interrupt_enable_reg[amt_pkg::INT_ENABLE_BIT];
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // all state moves in one register stage, so every output leaves a flip-flop
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cur <= '0;
      cur.value <= amt_pkg::VALUE_RESET;
    end else begin
      cur <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // outputs are plain views of the state register, with no logic after it
  assign rdata = cur.rdata;
  assign timer_up = cur.timer_up;
  assign multipurpose_compare_reg = cur.mpr;
  assign copy_done = cur.copy_done;
  assign timer_running = cur.running;
  assign irq = cur.irq;
endmodule
`default_nettype wire

// File: amt_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module amt_timer_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic sync_copy,
  input wire logic sync_start,
  input wire logic sync_stop,
  input wire logic timer_up,
  input wire logic [30:0] multipurpose_compare_reg,
  input wire logic copy_done,
  input wire logic timer_running,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic cmd = wr && addr == amt_pkg::OFF_COMMAND;
  wire logic go = sync_start || (cmd && wdata[7:0] == amt_pkg::CMD_START);
  wire logic halt = sync_stop || (cmd && wdata[7:0] == amt_pkg::CMD_STOP);
  sequence s_go;
    go && !halt;
  endsequence
  sequence s_halt;
    halt;
  endsequence
  a_start_runs: assert property (s_go |=> timer_running) else $error("no run after start");
  a_stop_halts: assert property (s_halt |=> !timer_running) else $error("run after stop");
  a_run_cause: assert property ($rose(timer_running) |-> $past(go)) else $error("run without start");
  a_end_cause: assert property ($fell(timer_running) |-> $past(halt) || timer_up) else $error("bad end");
  a_tick_spacing: assert property (timer_up |=> !timer_up [*8]) else $error("expiries too close");
  a_copy_pulse: assert property (sync_copy |=> copy_done) else $error("no copy pulse");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000) else $error("stray read data");
  a_irq_cause: assert property ($rose(irq) |-> timer_up || $past(wr)) else $error("irq without expiry");
endmodule
bind amt_timer amt_timer_sva u_sva (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sync_copy(sync_copy), .sync_start(sync_start), .sync_stop(sync_stop), .timer_up(timer_up),
  .multipurpose_compare_reg(multipurpose_compare_reg), .copy_done(copy_done), .timer_running(timer_running),
  .irq(irq));
`default_nettype wire

// File: amt_sync_model.sv
`timescale 1ns/1ps
`default_nettype none
// synchronous-action logic: bench requests are registered onto the sync inputs one cycle later
module amt_sync_model (
  input wire logic clock,
  input wire logic go_start,
  input wire logic go_copy,
  input wire logic stop_on_up,
  input wire logic timer_up,
  output logic sync_start = 1'b0,
  output logic sync_stop = 1'b0,
  output logic sync_copy = 1'b0
);
  always_ff @(posedge clock) begin
    sync_start <= go_start;
    sync_copy <= go_copy;
    sync_stop <= stop_on_up && timer_up;
  end
endmodule
`default_nettype wire

// File: test_axis_microsecond_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_microsecond_timer;
  logic clock = 0, resetn = 0, wr = 0, rd = 0, go_start = 0, go_copy = 0, stop_on_up = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic sync_copy, sync_start, sync_stop, timer_up, copy_done, timer_running, irq;
  logic [30:0] mcr;
  int n_mismatch = 0, num_checks = 0, n;
  amt_timer dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sync_copy(sync_copy), .sync_start(sync_start), .sync_stop(sync_stop), .timer_up(timer_up),
    .multipurpose_compare_reg(mcr), .copy_done(copy_done), .timer_running(timer_running), .irq(irq));
  amt_sync_model sync (.clock(clock), .go_start(go_start), .go_copy(go_copy), .stop_on_up(stop_on_up),
    .timer_up(timer_up), .sync_start(sync_start), .sync_stop(sync_stop), .sync_copy(sync_copy));
  initial forever #10 clock = ~clock;
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  // waits for expiry; lo and hi bound the cycle count, 16 cycles per microsecond
  task wup(input int lo, input int hi);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (timer_up !== 1'b1 && n < 2000);
    chk(32'(n >= lo && n <= hi), 32'h1);
    if (n == 2000) tally_and_finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk(timer_running, 32'h0);
    wreg(4'h9, 16'h0001);
    wreg(4'h1, 16'h0200);
    wreg(4'h6, 16'h0003);
    wreg(4'h7, 16'h0000);
    wreg(4'h0, 16'h0016);
    wreg(4'h0, 16'h0073);
    wup(45, 52);
    repeat (2) @(posedge clock);
    chk(timer_running, 32'h0);
    chk(irq, 32'h1);
    rreg(4'h8);
    chk(d, 32'h0200);
    wreg(4'h0, 16'h0038);
    rreg(4'h6);
    chk(d, 32'h0);
    wreg(4'h1, 16'h0000);
    wreg(4'h3, 16'h4000);
    wreg(4'h0, 16'h0073);
    wup(45, 52);
    wup(47, 49);
    chk(irq, 32'h0);
    rreg(4'h3);
    chk(d[10], 32'h1);
    go_copy <= 1'b1;
    @(posedge clock);
    go_copy <= 1'b0;
    repeat (2) @(posedge clock);
    chk(copy_done, 32'h1);
    chk(32'(mcr < 31'h3), 32'h1);
    wreg(4'h6, 16'h0001);
    wreg(4'h0, 16'h0016);
    wup(1, 17);
    stop_on_up <= 1'b1;
    wup(15, 17);
    repeat (3) @(posedge clock);
    chk(timer_running, 32'h0);
    stop_on_up <= 1'b0;
    go_start <= 1'b1;
    @(posedge clock);
    go_start <= 1'b0;
    repeat (2) @(posedge clock);
    chk(timer_running, 32'h1);
    wreg(4'h0, 16'h0074);
    @(posedge clock);
    chk(timer_running, 32'h0);
    rreg(4'hF);
    chk(d, 32'h0);
    wreg(4'h6, 16'h0010);
    wreg(4'h0, 16'h0016);
    wreg(4'h0, 16'h0073);
    repeat (40) @(posedge clock);
    wreg(4'h0, 16'h0038);
    rreg(4'h6);
    chk(d, 32'h2);
    rreg(4'h7);
    chk(d, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire
